// ===== logic/psc_pkg.sv
// Package of types and constants for the pin state controller
package psc_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  // Address bus goes low 2.5 clock cycles after reset is released;
  // rounded up to whole cycles of the block clock
  localparam int PSC_ADDR_LOW_HALF_CYC = 5;
  localparam int PSC_ADDR_LOW_CYC = (PSC_ADDR_LOW_HALF_CYC + 1) / 2;
  localparam logic [1:0] PSC_CNT_ZERO = 2'h0;
  localparam logic [1:0] PSC_CNT_ONE = 2'h1;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int PSC_ADDR_W = 20;
  localparam int PSC_TOP_W = 3;
  localparam int PSC_CS_W = 4;
  localparam int PSC_LCS_W = 4;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [PSC_ADDR_W-1:0] PSC_ADDR_RST = 20'h00000;
  localparam logic [PSC_TOP_W-1:0] PSC_TOP_RST = 3'h0;
  localparam logic [PSC_CS_W-1:0] PSC_CS_RST = 4'hF;

  // Pin condition, highest priority first
  typedef enum logic [2:0] {
    PSC_HW_STANDBY_PIN_N,
    PSC_RESET,
    PSC_SW_STANDBY_PIN_N,
    PSC_RELEASE,
    PSC_NORMAL
  } psc_cond_t;

  // Configuration bits
  typedef struct packed {
    logic standby_output_hold;
    logic bus_release_enable;
    logic clock_pin_stop;
    logic wide_mode;
    logic [PSC_CS_W-1:0] upper_select_enable;
    logic [PSC_TOP_W-1:0] top_address_enable;
    logic [PSC_LCS_W-1:0] lower_cs_dir;
  } psc_cfg_t;

  // One pin: output value and output enable
  typedef struct packed {
    logic val;
    logic oe;
  } psc_pin_t;

endpackage

// ===== logic/psc_pin_cell.sv
// Single pin state holder: drives, holds or floats one pin
`timescale 1ns/100ps
module psc_pin_cell
  import psc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic rst_val_in,
  input wire logic rst_oe_in,
  input wire logic hold_in,
  input wire psc_pkg::psc_pin_t req_in,
  output psc_pkg::psc_pin_t pin_out
);
  import psc_pkg::*;

  psc_pin_t pin_r;
  psc_pin_t pin_nxt;

  // ------------------------------------------------------------------
  // Next state: hold keeps a driven level, otherwise take request
  // ------------------------------------------------------------------
  always_comb begin
    if (hold_in) begin
      pin_nxt = pin_r; // Keep previous drive or float
    end else begin
      pin_nxt = req_in;
    end
  end

  // Register; reset state is float
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_r <= '0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  // Reset forces the asynchronous state straight onto the pin
  always_comb begin
    pin_out = pin_r;
  end

  // Input-configured pins never drive while held
  property p_hold_float;
    @(posedge clk_in) disable iff (!rstn_in)
      (hold_in && !pin_r.oe) |=> !pin_r.oe;
  endproperty
  a_hold_float: assert property (p_hold_float)
    else $error("held input pin started driving");

endmodule // psc_pin_cell

// ===== logic/psc_ctrl.sv
// Pin state controller for bus, strobe, select and clock pins
//
// Summary of operation
// - Reset: ports input, strobes high, data floats
// - Address driven low 3 cycles after reset release
// - Clock pin drives from first edge after reset release
// - Wide mode top address, selects float in reset
// - Hold: inputs float, address and top address keep their level, strobes and selects high
// - Address: standby hold bit, floats otherwise
// - Strobes high in reset, standby per hold bit
// - Lower selects follow direction, standby, release
// - Acknowledge pin: port or ack, low released
// - Request pin floats in every state, released and standby alike
// - Clock pin per stop bit in software standby, release and normal
// - Upper selects only when enables set
// - Top address only when enables clear
`timescale 1ns/100ps
module psc_ctrl
  import psc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic standby_pin_n_in,
  input wire logic sw_standby_in,
  input wire logic bus_released_in,
  input wire psc_pkg::psc_cfg_t cfg_in,
  input wire logic [PSC_ADDR_W-1:0] addr_in,
  input wire logic [PSC_TOP_W-1:0] top_addr_in,
  input wire logic strobe_n_in,
  input wire logic [PSC_CS_W-1:0] upper_cs_n_in,
  input wire logic [PSC_LCS_W-1:0] lower_cs_n_in,
  input wire logic bus_ack_in,
  input wire logic sys_clk_val_in,
  output logic [PSC_ADDR_W-1:0] addr_out,
  output logic addr_oe_out,
  output logic [PSC_TOP_W-1:0] top_addr_out,
  output logic [PSC_TOP_W-1:0] top_addr_oe_out,
  output logic strobe_n_out,
  output logic strobe_oe_out,
  output logic data_oe_out,
  output logic [PSC_CS_W-1:0] upper_cs_n_out,
  output logic [PSC_CS_W-1:0] upper_cs_oe_out,
  output logic [PSC_LCS_W-1:0] lower_cs_n_out,
  output logic [PSC_LCS_W-1:0] lower_cs_oe_out,
  output logic bus_ack_out,
  output logic bus_ack_oe_out,
  output logic bus_req_oe_out,
  output logic clk_pin_out,
  output logic clk_pin_oe_out,
  output logic port_oe_out
);
  import psc_pkg::*;

  // ------------------------------------------------------------------
  // Input synchronisers for off-chip standby pin
  // ------------------------------------------------------------------
  logic standby_pin_n_m_r;
  logic standby_pin_n_s_r;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      standby_pin_n_m_r <= 1'b1;
      standby_pin_n_s_r <= 1'b1;
    end else begin
      standby_pin_n_m_r <= standby_pin_n_in;
      standby_pin_n_s_r <= standby_pin_n_m_r;
    end
  end

  // ------------------------------------------------------------------
  // Reset tracking: counts cycles since reset was released
  // ------------------------------------------------------------------
  logic rst_m_r;       // Reset sampled, first stage
  logic rst_s_r;       // Reset released, synchronised
  logic [1:0] cnt_r;   // Cycles since reset
  logic [1:0] cnt_nxt;
  logic addr_low;      // Address bus driven low from the next edge
  logic in_rst;        // Reset state still in force

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end

  // Count advances after each reset until it saturates
  always_comb begin
    cnt_nxt = cnt_r;
    if (cnt_r != 2'(PSC_ADDR_LOW_CYC)) begin
      cnt_nxt = cnt_r + PSC_CNT_ONE;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r <= PSC_CNT_ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Address goes low on the edge that completes the count
  assign addr_low = (cnt_nxt == 2'(PSC_ADDR_LOW_CYC));

  // Reset state lasts until the address bus has been driven low
  assign in_rst = !rst_s_r || (cnt_r != 2'(PSC_ADDR_LOW_CYC));

  // ------------------------------------------------------------------
  // Condition select in priority order
  // ------------------------------------------------------------------
  psc_cond_t cond;

  always_comb begin
    if (!standby_pin_n_s_r) begin
      cond = PSC_HW_STANDBY_PIN_N;
    end else if (in_rst) begin
      cond = PSC_RESET;
    end else if (sw_standby_in) begin
      cond = PSC_SW_STANDBY_PIN_N;
    end else if (bus_released_in) begin
      cond = PSC_RELEASE;
    end else begin
      cond = PSC_NORMAL;
    end
  end

  // ------------------------------------------------------------------
  // Next pin states
  // ------------------------------------------------------------------
  logic [PSC_ADDR_W-1:0] addr_nxt;
  logic addr_oe_nxt;
  logic [PSC_TOP_W-1:0] top_nxt;
  logic [PSC_TOP_W-1:0] top_oe_nxt;
  logic strb_nxt;
  logic strb_oe_nxt;
  logic data_oe_nxt;
  logic [PSC_CS_W-1:0] ucs_nxt;
  logic [PSC_CS_W-1:0] ucs_oe_nxt;
  logic [PSC_LCS_W-1:0] lcs_nxt;
  logic [PSC_LCS_W-1:0] lcs_oe_nxt;
  logic ack_nxt;
  logic ack_oe_nxt;
  logic req_oe_nxt;
  logic clk_nxt;
  logic clk_oe_nxt;
  logic port_oe_nxt;
  logic hold_ack;     // Acknowledge pin keeps its state
  psc_pin_t ack_req;  // Requested acknowledge pin state
  psc_pin_t ack_pin;  // Registered acknowledge pin state

  always_comb begin
    // Defaults: keep pins as is, but data and request float, clock takes sys_clk_val_in
    addr_nxt = addr_out;
    addr_oe_nxt = addr_oe_out;
    top_nxt = top_addr_out;
    top_oe_nxt = top_addr_oe_out;
    strb_nxt = strobe_n_out;
    strb_oe_nxt = strobe_oe_out;
    data_oe_nxt = 1'b0;
    ucs_nxt = upper_cs_n_out;
    ucs_oe_nxt = upper_cs_oe_out;
    lcs_nxt = lower_cs_n_out;
    lcs_oe_nxt = lower_cs_oe_out;
    ack_nxt = bus_ack_out;
    ack_oe_nxt = bus_ack_oe_out;
    req_oe_nxt = 1'b0;
    clk_nxt = sys_clk_val_in;
    clk_oe_nxt = clk_pin_oe_out;
    port_oe_nxt = port_oe_out;
    hold_ack = 1'b0;
    case (cond)
      PSC_HW_STANDBY_PIN_N: begin
        // Every pin floats
        addr_oe_nxt = 1'b0;
        top_oe_nxt = '0;
        strb_oe_nxt = 1'b0;
        ucs_oe_nxt = '0;
        lcs_oe_nxt = '0;
        ack_oe_nxt = 1'b0;
        clk_oe_nxt = 1'b0;
        port_oe_nxt = 1'b0;
      end
      PSC_RESET: begin
        // Strobes high, ports input, selects float
        strb_nxt = 1'b1;
        strb_oe_nxt = 1'b1;
        port_oe_nxt = 1'b0;
        ucs_oe_nxt = '0;
        top_oe_nxt = '0;
        lcs_oe_nxt = '0;
        ack_oe_nxt = 1'b0;
        addr_nxt = PSC_ADDR_RST;
        addr_oe_nxt = addr_low;
        clk_oe_nxt = 1'b1;
      end
      PSC_SW_STANDBY_PIN_N: begin
        // Address held or floating by hold bit
        addr_oe_nxt = addr_oe_out && cfg_in.standby_output_hold;
        strb_nxt = 1'b1;
        strb_oe_nxt = cfg_in.standby_output_hold;
        for (int i = 0; i < PSC_TOP_W; i++) begin
          if (cfg_in.wide_mode && !cfg_in.top_address_enable[i]) begin
            top_oe_nxt[i] = top_addr_oe_out[i] &&
                            cfg_in.standby_output_hold;
          end
        end
        for (int i = 0; i < PSC_CS_W; i++) begin
          if (cfg_in.upper_select_enable[i]) begin
            ucs_nxt[i] = 1'b1;
            ucs_oe_nxt[i] = cfg_in.standby_output_hold;
          end
        end
        for (int i = 0; i < PSC_LCS_W; i++) begin
          lcs_nxt[i] = 1'b1;
          lcs_oe_nxt[i] = cfg_in.lower_cs_dir[i] &&
                          cfg_in.standby_output_hold;
        end
        if (cfg_in.bus_release_enable) begin
          ack_nxt = 1'b1;
          ack_oe_nxt = 1'b1;
        end else begin
          hold_ack = 1'b1;
        end
        if (!cfg_in.clock_pin_stop) begin
          clk_nxt = 1'b1;
          clk_oe_nxt = 1'b1;
        end
      end
      PSC_RELEASE: begin
        // Bus pins float, acknowledge driven low
        addr_oe_nxt = 1'b0;
        strb_oe_nxt = 1'b0;
        for (int i = 0; i < PSC_TOP_W; i++) begin
          if (cfg_in.wide_mode && !cfg_in.top_address_enable[i]) begin
            top_oe_nxt[i] = 1'b0;
          end
        end
        for (int i = 0; i < PSC_CS_W; i++) begin
          if (cfg_in.upper_select_enable[i]) begin
            ucs_oe_nxt[i] = 1'b0;
          end
        end
        for (int i = 0; i < PSC_LCS_W; i++) begin
          if (cfg_in.lower_cs_dir[i]) begin
            lcs_oe_nxt[i] = 1'b0;
          end
        end
        ack_nxt = 1'b0;
        ack_oe_nxt = 1'b1;
        clk_oe_nxt = !cfg_in.clock_pin_stop;
      end
      PSC_NORMAL: begin
        // Function pins drive their function
        addr_nxt = addr_in;
        addr_oe_nxt = 1'b1;
        strb_nxt = strobe_n_in;
        strb_oe_nxt = 1'b1;
        data_oe_nxt = 1'b0;
        port_oe_nxt = 1'b1;
        for (int i = 0; i < PSC_TOP_W; i++) begin
          if (cfg_in.wide_mode && !cfg_in.top_address_enable[i]) begin
            top_nxt[i] = top_addr_in[i];
            top_oe_nxt[i] = 1'b1;
          end
        end
        for (int i = 0; i < PSC_CS_W; i++) begin
          if (cfg_in.upper_select_enable[i]) begin
            ucs_nxt[i] = upper_cs_n_in[i];
            ucs_oe_nxt[i] = 1'b1;
          end
        end
        lcs_nxt = lower_cs_n_in;
        lcs_oe_nxt = cfg_in.lower_cs_dir;
        ack_nxt = bus_ack_in;
        ack_oe_nxt = cfg_in.bus_release_enable;
        req_oe_nxt = 1'b0;
        clk_oe_nxt = !cfg_in.clock_pin_stop;
      end
      default: begin
        port_oe_nxt = 1'b0;
      end
    endcase
  end

  // Acknowledge request packed for its pin cell
  always_comb begin
    ack_req.val = ack_nxt;
    ack_req.oe = ack_oe_nxt;
  end

  // Acknowledge pin cell: holds its drive or float when asked
  psc_pin_cell u_ack_cell (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .rst_val_in(1'b0),
    .rst_oe_in(1'b0),
    .hold_in(hold_ack),
    .req_in(ack_req),
    .pin_out(ack_pin)
  );

  // Registered acknowledge state straight to the pins
  assign bus_ack_out = ack_pin.val;
  assign bus_ack_oe_out = ack_pin.oe;

  // ------------------------------------------------------------------
  // Output registers; asynchronous reset gives the state at once
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr_out <= PSC_ADDR_RST;
      addr_oe_out <= 1'b0;
      top_addr_out <= PSC_TOP_RST;
      top_addr_oe_out <= '0;
      strobe_n_out <= 1'b1;
      strobe_oe_out <= 1'b1;
      data_oe_out <= 1'b0;
      upper_cs_n_out <= PSC_CS_RST;
      upper_cs_oe_out <= '0;
      lower_cs_n_out <= PSC_CS_RST;
      lower_cs_oe_out <= '0;
      bus_req_oe_out <= 1'b0;
      clk_pin_out <= 1'b0;
      clk_pin_oe_out <= 1'b0;
      port_oe_out <= 1'b0;
    end else begin
      addr_out <= addr_nxt;
      addr_oe_out <= addr_oe_nxt;
      top_addr_out <= top_nxt;
      top_addr_oe_out <= top_oe_nxt;
      strobe_n_out <= strb_nxt;
      strobe_oe_out <= strb_oe_nxt;
      data_oe_out <= data_oe_nxt;
      upper_cs_n_out <= ucs_nxt;
      upper_cs_oe_out <= ucs_oe_nxt;
      lower_cs_n_out <= lcs_nxt;
      lower_cs_oe_out <= lcs_oe_nxt;
      bus_req_oe_out <= req_oe_nxt;
      clk_pin_out <= clk_nxt;
      clk_pin_oe_out <= clk_oe_nxt;
      port_oe_out <= port_oe_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_in_reset;
    in_rst && standby_pin_n_s_r;
  endsequence

  property p_strobe_high_reset;
    @(posedge clk_in) disable iff (!rstn_in)
      s_in_reset |=> (strobe_n_out && strobe_oe_out);
  endproperty
  a_strobe_high_reset: assert property (p_strobe_high_reset)
    else $error("strobes not high during reset");

  property p_clk_drives_reset;
    @(posedge clk_in) disable iff (!rstn_in)
      s_in_reset |=> clk_pin_oe_out;
  endproperty
  a_clk_drives_reset: assert property (p_clk_drives_reset)
    else $error("clock pin not driving in reset");

  property p_addr_low_delay;
    @(posedge clk_in) disable iff (!rstn_in)
      (s_in_reset and (cnt_r == PSC_CNT_ZERO)) |=> !addr_oe_out;
  endproperty
  a_addr_low_delay: assert property (p_addr_low_delay)
    else $error("address driven too early in reset");

  property p_addr_low_drive;
    @(posedge clk_in) disable iff (!rstn_in)
      (s_in_reset and (cnt_r == 2'(PSC_ADDR_LOW_CYC - 1))) |=>
        (addr_oe_out && (addr_out == PSC_ADDR_RST));
  endproperty
  a_addr_low_drive: assert property (p_addr_low_drive)
    else $error("address not driven low in reset");

  property p_cs_float_reset;
    @(posedge clk_in) disable iff (!rstn_in)
      s_in_reset |=> (upper_cs_oe_out == '0 && top_addr_oe_out == '0);
  endproperty
  a_cs_float_reset: assert property (p_cs_float_reset)
    else $error("select or top address driven in reset");

  property p_release_float;
    @(posedge clk_in) disable iff (!rstn_in)
      (cond == PSC_RELEASE) |=> (!addr_oe_out && !strobe_oe_out
                                 && bus_ack_oe_out && !bus_ack_out);
  endproperty
  a_release_float: assert property (p_release_float)
    else $error("bus release pin state wrong");

  property p_sw_strobe;
    @(posedge clk_in) disable iff (!rstn_in)
      (cond == PSC_SW_STANDBY_PIN_N) |=>
        (strobe_oe_out == $past(cfg_in.standby_output_hold));
  endproperty
  a_sw_strobe: assert property (p_sw_strobe)
    else $error("strobe standby drive does not follow hold bit");

  property p_req_float;
    @(posedge clk_in) disable iff (!rstn_in)
      (cond == PSC_RELEASE) |=> !bus_req_oe_out;
  endproperty
  a_req_float: assert property (p_req_float)
    else $error("request pin driven during release");

  property p_hw_standby_pin_n_float;
    @(posedge clk_in) disable iff (!rstn_in)
      (cond == PSC_HW_STANDBY_PIN_N) |=> (!port_oe_out && !clk_pin_oe_out
                                 && !addr_oe_out);
  endproperty
  a_hw_standby_pin_n_float: assert property (p_hw_standby_pin_n_float)
    else $error("pin driven in hardware standby");

endmodule // psc_ctrl

// ===== bench/psc_seq_model.sv
// Reset and standby pin sequencer model for the pin state controller
`timescale 1ns/100ps
module psc_seq_model #(
  parameter int PRE_STANDBY_PIN_N_CYC = 10,
  parameter int EXIT_LEAD_CYC = 13
) (
  input wire logic clk_in,
  output logic rstn_out,
  output logic standby_n_out
);
  // ----------------------------------------------------------------
  // Pin drivers, changed only after a falling clock edge
  // ----------------------------------------------------------------
  // Power-up: reset asserted, standby released
  initial begin
    rstn_out = 1'b0;
    standby_n_out = 1'b1;
  end

  // Waits whole cycles on the falling edge
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Asserts the reset pin and leaves it low
  task automatic assert_reset();
    @(negedge clk_in);
    rstn_out = 1'b0;
  endtask

  // Releases the reset pin
  task automatic release_reset();
    @(negedge clk_in);
    rstn_out = 1'b1;
  endtask

  // Enters hardware standby; reset leads when RAM must be kept
  task automatic enter_standby(input logic ram_on);
    if (ram_on) begin
      assert_reset();
      wait_cyc(PRE_STANDBY_PIN_N_CYC);
    end
    // With RAM off standby may drop with reset high
    standby_n_out = 1'b0;
  endtask

  // Leaves hardware standby; reset stays low until the bench lets go
  task automatic exit_standby();
    assert_reset();
    wait_cyc(EXIT_LEAD_CYC);
    standby_n_out = 1'b1;
  endtask
endmodule // psc_seq_model

// ===== bench/pin_state_controller_bench.sv
// Self-checking testbench for the pin state controller
`timescale 1ns/100ps
module pin_state_controller_bench;
  import psc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_in;
  logic rstn_in;
  logic standby_pin_n_n;
  logic sw_standby_pin_n;
  logic rel;
  psc_cfg_t cfg;
  logic [PSC_ADDR_W-1:0] addr;
  logic [PSC_TOP_W-1:0] top;
  logic strb;
  logic [PSC_CS_W-1:0] ucs;
  logic [PSC_LCS_W-1:0] lcs;
  logic ack;
  logic sclk;
  logic [PSC_ADDR_W-1:0] addr_out;
  logic addr_oe_out;
  logic [PSC_TOP_W-1:0] top_addr_out;
  logic [PSC_TOP_W-1:0] top_addr_oe_out;
  logic strobe_n_out;
  logic strobe_oe_out;
  logic data_oe_out;
  logic [PSC_CS_W-1:0] upper_cs_n_out;
  logic [PSC_CS_W-1:0] upper_cs_oe_out;
  logic [PSC_LCS_W-1:0] lower_cs_n_out;
  logic [PSC_LCS_W-1:0] lower_cs_oe_out;
  logic bus_ack_out;
  logic bus_ack_oe_out;
  logic bus_req_oe_out;
  logic clk_pin_out;
  logic clk_pin_oe_out;
  logic port_oe_out;
  int fail_count = 0;
  int tests_run = 0;

  // 125 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  psc_seq_model u_seq (.clk_in(clk_in), .rstn_out(rstn_in),
    .standby_n_out(standby_pin_n_n));

  psc_ctrl u_dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .standby_pin_n_in(standby_pin_n_n), .sw_standby_in(sw_standby_pin_n),
    .bus_released_in(rel), .cfg_in(cfg), .addr_in(addr),
    .top_addr_in(top), .strobe_n_in(strb), .upper_cs_n_in(ucs),
    .lower_cs_n_in(lcs), .bus_ack_in(ack), .sys_clk_val_in(sclk),
    .addr_out(addr_out), .addr_oe_out(addr_oe_out),
    .top_addr_out(top_addr_out), .top_addr_oe_out(top_addr_oe_out),
    .strobe_n_out(strobe_n_out), .strobe_oe_out(strobe_oe_out),
    .data_oe_out(data_oe_out), .upper_cs_n_out(upper_cs_n_out),
    .upper_cs_oe_out(upper_cs_oe_out), .lower_cs_n_out(lower_cs_n_out),
    .lower_cs_oe_out(lower_cs_oe_out), .bus_ack_out(bus_ack_out),
    .bus_ack_oe_out(bus_ack_oe_out), .bus_req_oe_out(bus_req_oe_out),
    .clk_pin_out(clk_pin_out), .clk_pin_oe_out(clk_pin_oe_out),
    .port_oe_out(port_oe_out));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Compares one observed value, counting every comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Steps whole cycles; inputs change at the falling edge
  task automatic st(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Verdict and end of run
  task automatic close_out();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Standard bus configuration with a given standby hold bit
  task automatic base_cfg(input logic h);
    cfg = '0;
    cfg.standby_output_hold = h;
    cfg.bus_release_enable = 1'b1;
    cfg.wide_mode = 1'b1;
    cfg.upper_select_enable = 4'hF;
    cfg.lower_cs_dir = 4'hF;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sw_standby_pin_n = 1'b0;
    rel = 1'b0;
    cfg = '0;
    addr = 20'hABCDE;
    top = 3'h5;
    strb = 1'b1;
    ucs = 4'hA;
    lcs = 4'h5;
    ack = 1'b0;
    sclk = 1'b1;
    // Reset walk: clock pin first, address low at third edge
    st(16);
    u_seq.release_reset();
    st(1);
    chk(clk_pin_oe_out, 1);
    chk(addr_oe_out, 0);
    st(2);
    chk({addr_oe_out, addr_out}, {1'b1, 20'h00000});
    // Normal execution with all bus functions enabled
    base_cfg(1'b0);
    strb = 1'b0;
    st(4);
    chk({addr_oe_out, addr_out}, {1'b1, 20'hABCDE});
    chk({strobe_oe_out, strobe_n_out}, 2'b10);
    chk({upper_cs_oe_out, upper_cs_n_out}, 8'hFA);
    chk({top_addr_oe_out, top_addr_out}, 6'h3D);
    chk({lower_cs_oe_out, lower_cs_n_out}, 8'hF5);
    chk({bus_ack_oe_out, bus_ack_out}, 2'b10);
    chk(clk_pin_oe_out, 1);
    chk(port_oe_out, 1);
    // Clock stop set and lower selects turned to inputs
    cfg.clock_pin_stop = 1'b1;
    cfg.lower_cs_dir = 4'h0;
    st(4);
    chk(clk_pin_oe_out, 0);
    chk(lower_cs_oe_out, 4'h0);
    // Reset in mid access: strobes high, bus floats at once
    u_seq.assert_reset();
    #1;
    chk({strobe_oe_out, strobe_n_out}, 2'b11);
    chk({data_oe_out, port_oe_out, addr_oe_out}, 3'b000);
    chk({top_addr_oe_out, upper_cs_oe_out}, 7'h00);
    u_seq.release_reset();
    st(4);
    // Software standby, then bus release, per hold bit
    for (int h = 0; h < 2; h++) begin
      base_cfg(h[0]);
      addr = 20'h12345;
      st(4);
      // Release requested as well: software standby wins
      sw_standby_pin_n = 1'b1;
      rel = 1'b1;
      addr = 20'h0F0F0;
      st(4);
      chk(addr_oe_out, h);
      if (h == 1) begin
        chk(addr_out, 20'h12345);
        chk(strobe_n_out, 1);
        chk({lower_cs_n_out, upper_cs_n_out}, 8'hFF);
      end
      chk(strobe_oe_out, h);
      chk(lower_cs_oe_out, (h == 1) ? 4'hF : 4'h0);
      chk(upper_cs_oe_out, (h == 1) ? 4'hF : 4'h0);
      chk(top_addr_oe_out, (h == 1) ? 3'h7 : 3'h0);
      chk({bus_ack_oe_out, bus_ack_out}, 2'b11);
      chk(bus_req_oe_out, 0);
      chk({clk_pin_oe_out, clk_pin_out}, 2'b11);
      // Bus release alone
      sw_standby_pin_n = 1'b0;
      st(4);
      chk({addr_oe_out, strobe_oe_out}, 2'b00);
      chk({lower_cs_oe_out, upper_cs_oe_out}, 8'h00);
      chk({bus_ack_oe_out, bus_ack_out}, 2'b10);
      chk(bus_req_oe_out, 0);
      rel = 1'b0;
      st(4);
    end
    // Hardware standby without reset overrides every other state
    sw_standby_pin_n = 1'b1;
    rel = 1'b1;
    u_seq.enter_standby(1'b0);
    st(4);
    chk({addr_oe_out, strobe_oe_out, data_oe_out, port_oe_out}, 0);
    chk({lower_cs_oe_out, upper_cs_oe_out, top_addr_oe_out}, 0);
    chk({bus_ack_oe_out, clk_pin_oe_out, bus_req_oe_out}, 0);
    u_seq.exit_standby();
    sw_standby_pin_n = 1'b0;
    rel = 1'b0;
    u_seq.release_reset();
    st(6);
    // Standby keeping RAM: reset leads, then normal resumes
    u_seq.enter_standby(1'b1);
    st(4);
    u_seq.exit_standby();
    u_seq.release_reset();
    addr = 20'h5A5A5;
    st(6);
    chk({addr_oe_out, addr_out}, {1'b1, 20'h5A5A5});
    close_out();
  end
endmodule // pin_state_controller_bench
